//--- hdl/pdma_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PDMA_CFG_SVH
`define PDMA_CFG_SVH

// Clock rate and pulse widths.
`define CLK_MHZ 200
`define END_PULSE_NS 100
`define LAUNCH_PULSE_NS 200
`define SEC_RESET_PULSE_NS 200
`define NS_TO_CYCLES(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define END_PULSE_CYCLES `NS_TO_CYCLES(`END_PULSE_NS)
`define LAUNCH_PULSE_CYCLES `NS_TO_CYCLES(`LAUNCH_PULSE_NS)
`define SEC_RESET_PULSE_CYCLES `NS_TO_CYCLES(`SEC_RESET_PULSE_NS)

// Register byte addresses.
`define ADDR_W 5
`define OFF_OUT_DATA 5'h00
`define OFF_FUNC_OUT 5'h04
`define OFF_FUNC_IN 5'h08
`define OFF_STATUS 5'h0C
`define OFF_WORD_COUNT 5'h10
`define OFF_CONFIG 5'h14
`define OFF_LEGACY_BASE 5'h18
`define OFF_LEGACY_VECTOR 5'h1C

// Function output register fields.
`define FO_LINE_ONE 0
`define FO_LINE_TWO 1
`define FO_LINE_THREE 2
`define FO_REMOTE_RESET 3
`define FO_LAUNCH 4

// Function input register fields.
`define FI_STATUS_C 3
`define FI_STATUS_B 4
`define FI_STATUS_A 5

// Status register fields.
`define ST_READY 0
`define ST_BUSY 1
`define ST_DIRECTION 2
`define ST_ATTENTION 3

// Configuration register fields.
`define CFG_BUSY_HIGH 0

// Reset values.
`define RST_OUT_DATA 16'h0000
`define RST_FUNC_OUT 4'h0
`define RST_WORD_COUNT 16'h0000

// Legacy backplane base 760240 octal and vector 300 octal.
`define LEGACY_BASE 18'o760240
`define LEGACY_VECTOR 9'o300

// Positions within the synchronised pin vector.
`define PIN_W 23
`define PIN_REQ_A 0
`define PIN_REQ_B 1
`define PIN_ATTENTION_IN 2
`define PIN_STAT_A 3
`define PIN_STAT_B 4
`define PIN_STAT_C 5
`define PIN_DIR 6
`define PIN_DATA_LO 7

// Pulse timer slots.
`define PULSE_END 0
`define PULSE_LAUNCH 1
`define PULSE_SEC 2
`define PULSE_N 3

`endif

//--- hdl/pdma_pkg.sv
// Types shared by the parallel DMA user port modules.
`include "pdma_cfg.svh"

package pdma_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_DONE = 2'b10
   } xfer_state_t;

   typedef logic [`PIN_W-1:0] pin_vec_t;

   typedef struct packed {
      pin_vec_t s1;
      pin_vec_t s2;
      pin_vec_t s3;
      pin_vec_t filt;
      logic reqPrev;
      logic [15:0] outData;
      logic [3:0] funcOut;
      logic busyHigh;
      logic ready;
      xfer_state_t state;
      logic [15:0] wordCount;
      logic memReq;
      logic memWrite;
      logic [15:0] memWdata;
      logic busAck;
      logic [31:0] readData;
      logic busyPin;
      logic [`PULSE_N-1:0] fire;
   } port_state_t;

   typedef struct packed {
      logic [7:0] count;
      logic active;
   } pulse_state_t;

endpackage : pdma_pkg

//--- hdl/pulse_if.sv
// Trigger and busy pair between the port logic and a pulse timer.
`timescale 1ns/1ps
`default_nettype none

interface pulse_if;
   logic fire;
   logic active;
   modport owner (output fire, input active);
   modport timer (input fire, output active);
endinterface : pulse_if

`default_nettype wire

//--- hdl/pulse_timer.sv
// Fixed-width pulse generator, retriggered by each fire.
`timescale 1ns/1ps
`default_nettype none

module pulse_timer #(
   parameter logic [7:0] CYCLES = 8'h01
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Trigger and pulse
   pulse_if.timer pif
);
   import pdma_pkg::*;

   pulse_state_t cur;
   pulse_state_t nxt;

   always_comb begin
      nxt = cur;
      if (pif.fire) begin
         nxt.count = CYCLES;
      end else if (cur.count != 8'h00) begin
         nxt.count = cur.count - 8'h01;
      end
      nxt.active = (nxt.count != 8'h00);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign pif.active = cur.active;

endmodule : pulse_timer

`default_nettype wire

//--- hdl/parallel_dma_user_port.sv
// User-side control, status and register logic of the parallel DMA port.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

`include "pdma_cfg.svh"

module parallel_dma_user_port (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Avalon-MM register slave
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Memory word port of the DMA engine
   output logic memReq,
   output logic memWrite,
   output logic [15:0] memWdata,
   input wire logic [15:0] memRdata,
   input wire logic memAck,
   input wire logic memError,
   // User connector inputs
   input wire logic [15:0] inDataLines,
   input wire logic cycleRequestA,
   input wire logic cycleRequestB,
   input wire logic attentionIn,
   input wire logic statusInA,
   input wire logic statusInB,
   input wire logic statusInC,
   input wire logic directionSelectIn,
   input wire logic wordCountStepIn,
   // User connector outputs
   output logic [15:0] outDataLines,
   output logic cycleDonePulse,
   output logic readyOut,
   output logic launchOut,
   output logic busyOut,
   output logic initOut,
   output logic secondaryResetOut,
   output logic [2:0] functionLines
);
   import pdma_pkg::*;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                input logic [`ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      merge16 = r;
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////

   localparam logic [7:0] PULSE_LEN [`PULSE_N] = '{
      8'(`END_PULSE_CYCLES),
      8'(`LAUNCH_PULSE_CYCLES),
      8'(`SEC_RESET_PULSE_CYCLES)
   };

   port_state_t cur;
   port_state_t nxt;
   logic [`PULSE_N-1:0] pulseActive;
   pin_vec_t pinsRaw;
   logic reqNow;
   logic reqRise;
   logic busWr;
   logic busRd;
   logic [31:0] rdMux;

   pulse_if pbus[`PULSE_N] ();

   genvar g;
   generate
      for (g = 0; g < `PULSE_N; g++) begin : gen_pulse
         assign pbus[g].fire = cur.fire[g];
         assign pulseActive[g] = pbus[g].active;
         pulse_timer #(
            .CYCLES(PULSE_LEN[g])
         ) u_timer (
            .mclk(mclk),
            .rst(rst),
            .pif(pbus[g])
         );
      end
   endgenerate

   // The word count step pin is deliberately left unread.
   assign pinsRaw = {inDataLines, directionSelectIn, statusInC, statusInB,
                     statusInA, attentionIn, cycleRequestB, cycleRequestA};

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      nxt = cur;
      nxt.fire = '0;

      // Three stages; a bit counts once stages two and three agree.
      nxt.s1 = pinsRaw;
      nxt.s2 = cur.s1;
      nxt.s3 = cur.s2;
      for (int i = 0; i < `PIN_W; i++) begin
         if (cur.s2[i] == cur.s3[i]) begin
            nxt.filt[i] = cur.s3[i];
         end
      end

      reqNow = cur.filt[`PIN_REQ_A] | cur.filt[`PIN_REQ_B];
      reqRise = reqNow & ~cur.reqPrev;
      nxt.reqPrev = reqNow;

      // One wait state per access: readdata is loaded while waiting.
      busWr = write & ~read;
      busRd = read & ~write;
      nxt.busAck = (busWr | busRd) & ~cur.busAck;

      rdMux = 32'h0000_0000;
      if (hit(address, `OFF_OUT_DATA)) begin
         rdMux[15:0] = cur.outData;
      end
      if (hit(address, `OFF_FUNC_OUT)) begin
         rdMux[3:0] = cur.funcOut;
      end
      if (hit(address, `OFF_FUNC_IN)) begin
         rdMux[`FI_STATUS_A] = cur.filt[`PIN_STAT_A];
         rdMux[`FI_STATUS_B] = cur.filt[`PIN_STAT_B];
         rdMux[`FI_STATUS_C] = cur.filt[`PIN_STAT_C];
      end
      if (hit(address, `OFF_STATUS)) begin
         rdMux[`ST_READY] = cur.ready;
         rdMux[`ST_BUSY] = (cur.state == ST_FETCH);
         rdMux[`ST_DIRECTION] = cur.filt[`PIN_DIR];
         rdMux[`ST_ATTENTION] = cur.filt[`PIN_ATTENTION_IN];
      end
      if (hit(address, `OFF_WORD_COUNT)) begin
         rdMux[15:0] = cur.wordCount;
      end
      if (hit(address, `OFF_CONFIG)) begin
         rdMux[`CFG_BUSY_HIGH] = cur.busyHigh;
      end
      if (hit(address, `OFF_LEGACY_BASE)) begin
         rdMux[17:0] = `LEGACY_BASE;
      end
      if (hit(address, `OFF_LEGACY_VECTOR)) begin
         rdMux[8:0] = `LEGACY_VECTOR;
      end
      if (busRd & ~cur.busAck) begin
         nxt.readData = rdMux;
      end

      // Register writes take effect on the acknowledging edge.
      if (busWr & cur.busAck) begin
         if (hit(address, `OFF_OUT_DATA)) begin
            nxt.outData = merge16(cur.outData, writedata, byteenable);
         end
         if (hit(address, `OFF_FUNC_OUT) & byteenable[0]) begin
            nxt.funcOut = writedata[3:0];
            if (writedata[`FO_LINE_TWO] & ~cur.funcOut[`FO_LINE_TWO]) begin
               nxt.fire[`PULSE_SEC] = 1'b1;
            end
            if (writedata[`FO_LAUNCH]) begin
               nxt.ready = 1'b0;
               nxt.fire[`PULSE_LAUNCH] = 1'b1;
            end
         end
         if (hit(address, `OFF_WORD_COUNT)) begin
            nxt.wordCount = merge16(cur.wordCount, writedata, byteenable);
         end
         if (hit(address, `OFF_CONFIG) & byteenable[0]) begin
            nxt.busyHigh = writedata[`CFG_BUSY_HIGH];
         end
      end

      // Transfer sequencer.
      case (cur.state)
         ST_IDLE: begin
            if (reqRise & ~cur.ready) begin
               nxt.state = ST_FETCH;
               nxt.memReq = 1'b1;
               nxt.memWrite = cur.filt[`PIN_DIR];
               nxt.memWdata = cur.filt[`PIN_DATA_LO +: 16];
            end
         end
         ST_FETCH: begin
            if (memError) begin
               nxt.memReq = 1'b0;
               nxt.ready = 1'b1;
               nxt.state = ST_IDLE;
            end else if (memAck) begin
               nxt.memReq = 1'b0;
               if (~cur.memWrite) begin
                  nxt.outData = memRdata;
               end
               nxt.wordCount = cur.wordCount + 16'h0001;
               nxt.fire[`PULSE_END] = 1'b1;
               nxt.state = ST_DONE;
            end
         end
         ST_DONE: begin
            // Requests arriving during the pulse are dropped.
            if (~cur.fire[`PULSE_END] & ~pulseActive[`PULSE_END]) begin
               nxt.state = ST_IDLE;
            end
         end
         default: begin
            nxt.state = ST_IDLE;
            nxt.memReq = 1'b0;
         end
      endcase

      // Attention wins over launch and ends any transfer at once.
      if (cur.filt[`PIN_ATTENTION_IN]) begin
         nxt.ready = 1'b1;
         nxt.memReq = 1'b0;
         if (cur.state == ST_FETCH) begin
            nxt.state = ST_IDLE;
         end
      end

      nxt.busyPin = (nxt.state == ST_FETCH) ~^ nxt.busyHigh;
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk) begin
      if (rst) begin
         cur <= '0;
         cur.outData <= `RST_OUT_DATA;
         cur.funcOut <= `RST_FUNC_OUT;
         cur.wordCount <= `RST_WORD_COUNT;
         cur.ready <= 1'b1;
         cur.state <= ST_IDLE;
         cur.busyPin <= 1'b1;
      end else begin
         cur <= nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // About 25 clocks per word at 200 MHz, far above 4 Mbyte/s.
   assign waitrequest = (read | write) & ~cur.busAck;
   assign readdata = cur.readData;
   assign memReq = cur.memReq;
   assign memWrite = cur.memWrite;
   assign memWdata = cur.memWdata;
   assign outDataLines = cur.outData;
   assign cycleDonePulse = pulseActive[`PULSE_END];
   assign readyOut = cur.ready;
   assign launchOut = pulseActive[`PULSE_LAUNCH];
   assign busyOut = cur.busyPin;
   assign initOut = rst | cur.funcOut[`FO_REMOTE_RESET];
   assign secondaryResetOut = rst | pulseActive[`PULSE_SEC];
   assign functionLines = cur.funcOut[`FO_LINE_THREE:`FO_LINE_ONE];

endmodule : parallel_dma_user_port

`default_nettype wire

//--- verif/pdma_user_monitor.sv
// Concurrent checks on the parallel DMA user port pins.
`timescale 1ns/1ps
`default_nettype none

`include "pdma_cfg.svh"

module pdma_user_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register bus
   input wire logic [`ADDR_W-1:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic waitrequest,
   // Memory port
   input wire logic memReq,
   input wire logic memAck,
   input wire logic memError,
   // User connector
   input wire logic attentionIn,
   input wire logic [15:0] outDataLines,
   input wire logic cycleDonePulse,
   input wire logic readyOut,
   input wire logic launchOut,
   input wire logic initOut,
   input wire logic secondaryResetOut,
   input wire logic [2:0] functionLines
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   logic [7:0] doneCnt;
   logic [7:0] goCnt;
   logic foWr;

   // Pulse widths are counted here; a repetition of 40 would be too slow.
   always_ff @(posedge mclk) begin
      doneCnt <= (rst || !cycleDonePulse) ? 8'h00 : doneCnt + 8'h01;
      goCnt <= (rst || !launchOut) ? 8'h00 : goCnt + 8'h01;
   end
   assign foWr = write && !waitrequest && address == `OFF_FUNC_OUT &&
      byteenable[0];

   a_out_data: assert property (write && !waitrequest &&
      address == `OFF_OUT_DATA && byteenable[1:0] == 2'b11 |=>
      outDataLines == $past(writedata[15:0]))
      else $error("output lines differ from written data");
   a_ready_blocks: assert property (readyOut && !memReq |=> !memReq)
      else $error("transfer started while ready");
   a_done_width: assert property ($fell(cycleDonePulse) |->
      doneCnt == 8'h14) else $error("end pulse width wrong");
   a_done_after_ack: assert property (memReq && memAck && !memError &&
      !attentionIn |=> !memReq ##1 cycleDonePulse)
      else $error("end pulse not after memory ack");
   a_no_rerequest: assert property (cycleDonePulse |=> !$rose(memReq))
      else $error("request taken during end pulse");
   a_launch_ready: assert property (foWr && writedata[`FO_LAUNCH] &&
      !attentionIn |=> !readyOut ##[0:2] launchOut)
      else $error("launch did not drop ready");
   a_launch_width: assert property ($fell(launchOut) |->
      goCnt == 8'h28) else $error("launch pulse width wrong");
   a_init_follow: assert property (foWr |=>
      initOut == $past(writedata[`FO_REMOTE_RESET]) &&
      functionLines == $past(writedata[2:0]))
      else $error("function outputs differ from write");
   a_sec_pulse: assert property (foWr && writedata[`FO_LINE_TWO] &&
      !functionLines[1] |-> ##[1:3] secondaryResetOut)
      else $error("secondary reset pulse missing");
   a_attention_in_ready: assert property (attentionIn [*8] |->
      readyOut && !memReq) else $error("attention did not set ready");
endmodule : pdma_user_monitor

bind parallel_dma_user_port pdma_user_monitor pdma_user_monitor_i (.mclk,
   .rst, .address, .write, .writedata, .byteenable, .waitrequest, .memReq,
   .memAck, .memError, .attentionIn, .outDataLines, .cycleDonePulse,
   .readyOut, .launchOut, .initOut, .secondaryResetOut, .functionLines);

`default_nettype wire

//--- verif/user_equipment_model.sv
// User equipment that raises cycle requests and holds input data.
`timescale 1ns/1ps
`default_nettype none

module user_equipment_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Commands from the bench
   input wire logic trig,
   input wire logic useB,
   input wire logic toMem,
   input wire logic [15:0] word,
   // User connector
   output logic cycleRequestA,
   output logic cycleRequestB,
   output logic directionSelectIn,
   output logic [15:0] inDataLines
);
   logic [5:0] hold;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hold <= 6'h00;
         inDataLines <= 16'hA5A5;
         directionSelectIn <= 1'b0;
      end else if (trig) begin
         hold <= 6'h28;
         inDataLines <= word;
         directionSelectIn <= toMem;
      end else if (hold != 6'h00) begin
         hold <= hold - 6'h01;
      end else begin
         // Released lines toggle so no stale word can pass for a fresh one.
         inDataLines <= ~inDataLines;
      end
   end
   // The unused request line stays grounded.
   assign cycleRequestA = hold > 6'h20 && !useB;
   assign cycleRequestB = hold > 6'h20 && useB;
endmodule : user_equipment_model

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the parallel DMA user port.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic mclk = 0, rst = 1, read = 0, write = 0, memAck = 0, memError = 0;
   logic attentionIn = 0, statusInA = 0, statusInB = 0, statusInC = 0;
   logic wordCountStepIn = 0, trig = 0, useB = 0, toMem = 0, errMode = 0;
   logic sawReq = 0, busyHigh = 0, donePrev = 0;
   logic [4:0] address = 0;
   logic [31:0] writedata = 0, readdata;
   logic [15:0] memRdata = 0, word = 0, expOut = 0, rnd, memWdata;
   logic [15:0] outDataLines, inDataLines;
   logic waitrequest, memReq, memWrite, cycleDonePulse, readyOut, launchOut;
   logic busyOut, initOut, secondaryResetOut;
   logic cycleRequestA, cycleRequestB, directionSelectIn;
   logic [2:0] functionLines;
   logic [1:0] dly = 0;
   logic [31:0] rdQ[$];
   logic [15:0] odQ[$], mwQ[$];
   int n_errors = 0, n_checks = 0, wc = 0, nDone = 0, i, n;

   always #2.5 mclk = ~mclk;

   parallel_dma_user_port parallel_dma_user_port_i (.mclk, .rst, .address,
      .read, .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest,
      .memReq, .memWrite, .memWdata, .memRdata, .memAck, .memError,
      .inDataLines, .cycleRequestA, .cycleRequestB, .attentionIn, .statusInA,
      .statusInB, .statusInC, .directionSelectIn, .wordCountStepIn,
      .outDataLines, .cycleDonePulse, .readyOut, .launchOut, .busyOut,
      .initOut, .secondaryResetOut, .functionLines);
   user_equipment_model user_equipment_model_i (.mclk, .rst, .trig, .useB,
      .toMem, .word, .cycleRequestA, .cycleRequestB, .directionSelectIn,
      .inDataLines);

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (n_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic timeout;
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      test_done();
   endtask : timeout

   // A read passes its expected word as data; the posedge checker block in tb_top compares it.
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      if (!wr) rdQ.push_back(d);
      @(posedge mclk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      do begin
         @(posedge mclk);
         k++;
      end while (waitrequest && k < 20);
      if (waitrequest) timeout();
      read <= 0;
      write <= 0;
   endtask : bus

   task automatic dma(input int k);
      rnd = 16'($urandom);
      word <= rnd;
      useB <= k[0];
      toMem <= k[1];
      wordCountStepIn <= 1'($urandom);
      if (k[1]) mwQ.push_back(rnd);
      trig <= 1;
      @(posedge mclk);
      trig <= 0;
      n = 0;
      // An aborted transfer gives no end pulse; ready coming back ends it.
      do begin
         @(posedge mclk);
         n++;
      end while (nDone <= k && !(errMode && readyOut) && n < 400);
      if (nDone <= k && !(errMode && readyOut)) timeout();
   endtask : dma

   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (read && !waitrequest) chk(readdata, rdQ.pop_front());
      if (cycleDonePulse && !donePrev) chk(outDataLines, odQ.pop_front());
      if (!cycleDonePulse && donePrev) nDone++;
      donePrev <= cycleDonePulse;
   end

   // Memory side of the engine answers after a random delay.
   always @(posedge mclk) begin
      memAck <= 0;
      memError <= 0;
      if (memReq) sawReq <= 1;
      if (memReq && !memAck && !memError) begin
         chk(busyOut, busyHigh);
         if (dly != 0) begin
            dly <= dly - 1;
         end else if (errMode) begin
            memError <= 1;
         end else begin
            dly <= 2'($urandom);
            rnd = 16'($urandom);
            memRdata <= rnd;
            memAck <= 1;
            if (memWrite) chk(memWdata, mwQ.pop_front());
            if (!memWrite) expOut = rnd;
            odQ.push_back(expOut);
            wc++;
         end
      end
   end

   initial begin
      void'($urandom(32'h7770CB5C));
      repeat (5) @(posedge mclk);
      rst <= 0;
      chk(readyOut, 1);
      bus(0, 5'h18, 32'h0003E0A0);
      bus(0, 5'h1C, 32'h000000C0);
      bus(0, 5'h02, 32'h00000000);
      for (i = 0; i < 3; i++) begin
         expOut = 16'($urandom);
         bus(1, 5'h00, {16'h0000, expOut});
         bus(0, 5'h00, {16'h0000, expOut});
      end
      for (i = 0; i < 4; i++) begin
         {statusInA, statusInB, statusInC} <= 3'($urandom);
         repeat (8) @(posedge mclk);
         bus(0, 5'h08, {26'h0, statusInA, statusInB, statusInC, 3'h0});
      end
      bus(1, 5'h04, 32'h0000000A);
      bus(0, 5'h04, 32'h0000000A);
      bus(1, 5'h04, 32'h00000000);
      bus(1, 5'h04, 32'h00000010);
      @(posedge mclk);
      chk(readyOut, 0);
      for (i = 0; i < 6; i++) begin
         if (i == 4) begin
            bus(1, 5'h14, 32'h00000001);
            busyHigh = 1;
         end
         dma(i);
      end
      bus(0, 5'h10, 32'h00000006);
      errMode = 1;
      dma(6);
      errMode = 0;
      chk(readyOut, 1);
      bus(0, 5'h10, 32'h00000006);
      bus(1, 5'h04, 32'h00000010);
      attentionIn <= 1;
      repeat (10) @(posedge mclk);
      chk(readyOut, 1);
      sawReq = 0;
      trig <= 1;
      @(posedge mclk);
      trig <= 0;
      repeat (40) @(posedge mclk);
      chk(sawReq, 0);
      attentionIn <= 0;
      test_done();
   end
endmodule : tb_top

`default_nettype wire
